// [hdl/compare_timer_pwm.v]
`include "compare_timer_pwm_defines.vh"
module compare_timer_pwm #(
	parameter CNT_W = `CNT_W,
	parameter IRQ_SRC_INDEX = 12
) (
	// Clock and reset
	input wire sys_clk,
	input wire arst_n,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output reg [31:0] prdata,
	output wire pslverr,
	// External timer sync and trip
	input wire pwmTimerSyncOut,
	input wire tripIn,
	// Phase outputs: A high, A low, B high, B low, C high, C low
	output wire [5:0] axis4Phase,
	output wire [5:0] axis5Phase,
	output wire [5:0] axis6Phase,
	// Filter triggers and period requests
	output reg [1:0] sampleTrigger_r,
	output reg [1:0] periodIrq_r
);

	////////////////////////////////////////////////////////////////
	// Register file
	reg [1:0] ctrl_r;
	reg [CNT_W-1:0] period0_r;
	reg [CNT_W-1:0] period1_r;
	reg [`NUM_OUT-1:0] outEn_r;
	reg [`NUM_OUT-1:0] initLvl_r;
	reg [`NUM_OUT-1:0] actLvl_r;
	reg [`NUM_OUT-1:0] tripLvl_r;
	reg [15:0] deadBand_r;
	reg [CNT_W-1:0] cnt0_r;
	reg [CNT_W-1:0] cnt1_r;
	reg [CNT_W-1:0] shadowRd;
	reg [`NUM_OUT-1:0] pinLvl_r;
	wire [CNT_W-1:0] shadowVal [0:`NUM_CH-1];
	wire [`NUM_OUT-1:0] pinNxt;
	wire [`NUM_CH-1:0] chMatch;
	wire access;
	wire wrEn;
	wire cmpHit;
	wire mapped;
	wire [4:0] cmpIdx;
	wire [11:0] cmpOff;
	wire clear0;
	wire clear1;
	wire wrap0;
	wire wrap1;
	wire tripAct;
	wire [`NUM_OUT-1:0] legOn;
	wire [`NUM_OUT-1:0] legPend;
	reg [31:0] rdData_nxt;
	localparam [CNT_W-1:0] PERIOD_INIT = `PERIOD_RESET;
	integer k;

	assign access = psel & penable;
	assign wrEn = access & pwrite;
	assign pready = 1'b1;
	assign cmpOff = paddr - `REG_CMP_BASE;
	assign cmpIdx = cmpOff[6:2];
	assign cmpHit = (paddr >= `REG_CMP_BASE) && (paddr <= `REG_CMP_LAST) && (paddr[1:0] == 2'h0);
	assign mapped = cmpHit || (paddr <= `REG_STATUS && paddr[1:0] == 2'h0);
	assign pslverr = access & ~mapped;

	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_r <= 2'h0;
			period0_r <= PERIOD_INIT;
			period1_r <= PERIOD_INIT;
			outEn_r <= {`NUM_OUT{1'b0}};
			initLvl_r <= {`NUM_OUT{1'b0}};
			actLvl_r <= {`NUM_OUT{1'b1}};
			tripLvl_r <= {`NUM_OUT{1'b0}};
			deadBand_r <= 16'h0000;
		end else if (wrEn) begin
			case (paddr)
				`REG_CTRL: ctrl_r <= pwdata[1:0];
				`REG_PERIOD0: period0_r <= pwdata[CNT_W-1:0];
				`REG_PERIOD1: period1_r <= pwdata[CNT_W-1:0];
				`REG_OUT_EN: outEn_r <= pwdata[`NUM_OUT-1:0];
				`REG_INIT_LVL: initLvl_r <= pwdata[`NUM_OUT-1:0];
				`REG_ACT_LVL: actLvl_r <= pwdata[`NUM_OUT-1:0];
				`REG_TRIP_LVL: tripLvl_r <= pwdata[`NUM_OUT-1:0];
				`REG_DEADBAND: deadBand_r <= pwdata[15:0];
				default: ctrl_r <= ctrl_r;
			endcase
		end
	end

	always @* begin
		shadowRd = {CNT_W{1'b0}};
		for (k = 0; k < `NUM_CH; k = k + 1) begin
			if (cmpIdx == k[4:0])
				shadowRd = shadowVal[k];
		end
	end

	always @* begin
		rdData_nxt = 32'h0000_0000;
		if (cmpHit) begin
			rdData_nxt[CNT_W-1:0] = shadowRd;
		end else begin
			case (paddr)
				`REG_CTRL: rdData_nxt[1:0] = ctrl_r;
				`REG_PERIOD0: rdData_nxt[CNT_W-1:0] = period0_r;
				`REG_PERIOD1: rdData_nxt[CNT_W-1:0] = period1_r;
				`REG_OUT_EN: rdData_nxt[`NUM_OUT-1:0] = outEn_r;
				`REG_INIT_LVL: rdData_nxt[`NUM_OUT-1:0] = initLvl_r;
				`REG_ACT_LVL: rdData_nxt[`NUM_OUT-1:0] = actLvl_r;
				`REG_TRIP_LVL: rdData_nxt[`NUM_OUT-1:0] = tripLvl_r;
				`REG_DEADBAND: rdData_nxt[15:0] = deadBand_r;
				`REG_STATUS: rdData_nxt = {cnt1_r, cnt0_r};
				default: rdData_nxt = 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Read path
	// Captured in the setup cycle, so the access cycle sees a flop, not a mux
	// Limitation: status is a snapshot taken one cycle before the access edge
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= rdData_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	// Cycle counters
	// Match at the period value: counter spans period plus one counts
	assign wrap0 = (cnt0_r == period0_r);
	assign wrap1 = (cnt1_r == period1_r);
	assign clear0 = ctrl_r[`CTRL_RUN] & (wrap0 | pwmTimerSyncOut);
	assign clear1 = ctrl_r[`CTRL_RUN] & (wrap1 | pwmTimerSyncOut);
	assign tripAct = tripIn | ctrl_r[`CTRL_TRIP];

	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt0_r <= {CNT_W{1'b0}};
			cnt1_r <= {CNT_W{1'b0}};
			periodIrq_r <= 2'h0;
		end else begin
			// One count per clock, no prescale, to stay aligned
			if (clear0)
				cnt0_r <= {CNT_W{1'b0}};
			else if (ctrl_r[`CTRL_RUN])
				cnt0_r <= cnt0_r + 1'b1;
			if (clear1)
				cnt1_r <= {CNT_W{1'b0}};
			else if (ctrl_r[`CTRL_RUN])
				cnt1_r <= cnt1_r + 1'b1;
			periodIrq_r <= {ctrl_r[`CTRL_RUN] & wrap1, ctrl_r[`CTRL_RUN] & wrap0};
		end
	end

	////////////////////////////////////////////////////////////////
	// Compare channels: 0..11 on timer 0, 12..19 on timer 1
	genvar g;
	generate
		for (g = 0; g < `NUM_CH; g = g + 1) begin : chan
			reg [CNT_W-1:0] shadow_r;
			reg [CNT_W-1:0] active_r;
			wire onT0;
			wire clr;
			wire [CNT_W-1:0] cnt;
			localparam [4:0] CH_IDX = g;
			assign onT0 = (g < `T0_CH);
			assign clr = onT0 ? clear0 : clear1;
			assign cnt = onT0 ? cnt0_r : cnt1_r;
			assign shadowVal[g] = shadow_r;
			// Active value hit while running and not at the clearing count
			assign chMatch[g] = ctrl_r[`CTRL_RUN] & ~clr & (cnt == active_r);
			always @(posedge sys_clk or negedge arst_n) begin
				if (!arst_n) begin
					shadow_r <= {CNT_W{1'b0}};
					active_r <= {CNT_W{1'b0}};
				end else begin
					if (wrEn && cmpHit && cmpIdx == CH_IDX)
						shadow_r <= pwdata[CNT_W-1:0];
					if (clr)
						active_r <= shadow_r;
				end
			end
			if (g < `NUM_OUT) begin : outp
				reg pend_r;
				reg on_r;
				reg [15:0] dly_r;
				wire partnerBusy;
				// Assert only after the dead-band has run out
				always @(posedge sys_clk or negedge arst_n) begin
					if (!arst_n) begin
						pend_r <= 1'b0;
						on_r <= 1'b0;
						dly_r <= 16'h0000;
					end else if (clr || !outEn_r[g]) begin
						pend_r <= 1'b0;
						on_r <= 1'b0;
						dly_r <= 16'h0000;
					end else if (chMatch[g] && !on_r) begin
						pend_r <= 1'b1;
						dly_r <= deadBand_r;
					end else if (pend_r) begin
						if (partnerBusy) begin
							// Other switch of the leg conducts, or for a low side is pending: restart dead time
							dly_r <= deadBand_r;
						end else if (dly_r == 16'h0000) begin
							pend_r <= 1'b0;
							on_r <= 1'b1;
						end else begin
							dly_r <= dly_r - 16'h0001;
						end
					end
				end
				assign legOn[g] = on_r;
				assign legPend[g] = pend_r;
				// Low side yields to a pending high side, so a shared match cannot short a leg
				if (g % 2 == 1) begin : lowSide
					assign partnerBusy = legOn[g ^ 1] | legPend[g ^ 1];
				end else begin : highSide
					assign partnerBusy = legOn[g ^ 1];
				end
				// Disabled outputs sit at the initial level
				assign pinNxt[g] = !outEn_r[g] ? initLvl_r[g] :
					tripAct ? tripLvl_r[g] :
					on_r ? actLvl_r[g] : initLvl_r[g];
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// Pins and filter triggers
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pinLvl_r <= {`NUM_OUT{1'b0}};
			sampleTrigger_r <= 2'h0;
		end else begin
			pinLvl_r <= pinNxt;
			sampleTrigger_r <= chMatch[19:18];
		end
	end

	assign axis6Phase = pinLvl_r[5:0];
	assign axis5Phase = pinLvl_r[11:6];
	assign axis4Phase = pinLvl_r[17:12];

endmodule

// [hdl/compare_timer_pwm_defines.vh]
`ifndef COMPARE_TIMER_PWM_DEFINES_VH
`define COMPARE_TIMER_PWM_DEFINES_VH

// Count clock and PWM rate
`define CLK_HZ 250000000
`define PWM_HZ 16000
// Period compare value, count clock over PWM rate, halved
`define PERIOD_RESET 7812
`define CNT_W 16

// Register byte addresses
`define REG_CTRL 12'h000
`define REG_PERIOD0 12'h004
`define REG_PERIOD1 12'h008
`define REG_OUT_EN 12'h00C
`define REG_INIT_LVL 12'h010
`define REG_ACT_LVL 12'h014
`define REG_TRIP_LVL 12'h018
`define REG_DEADBAND 12'h01C
`define REG_STATUS 12'h020
`define REG_CMP_BASE 12'h040
`define REG_CMP_LAST 12'h08C

// Control fields
`define CTRL_RUN 0
`define CTRL_TRIP 1

// Channel counts
`define NUM_CH 20
`define NUM_OUT 18
`define T0_CH 12

`endif

// [dv/gate_driver_model.sv]
module gate_driver_model (
	// Gate inputs, high then low per leg
	input wire [17:0] gates,
	// Both switches of one leg on
	output wire shootThrough
);
	timeunit 1ns;
	timeprecision 1ps;
	// A leg with both gates on shorts the supply
	assign shootThrough = |(gates & {gates[16:0], 1'b0} & 18'h2AAAA);
endmodule

// [dv/compare_timer_pwm_props.sv]
module compare_timer_pwm_props (
	// Clock and reset
	input wire sys_clk,
	input wire arst_n,
	// APB
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire pready,
	input wire [31:0] prdata,
	input wire pslverr,
	// Pins
	input wire [5:0] axis4Phase,
	input wire [5:0] axis5Phase,
	input wire [5:0] axis6Phase,
	input wire [1:0] sampleTrigger_r,
	input wire [1:0] periodIrq_r
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	sequence access;
		psel && penable;
	endsequence
	sequence quietPins;
		axis4Phase == 6'h0 && axis5Phase == 6'h0 && axis6Phase == 6'h0 && periodIrq_r == 2'h0;
	endsequence
	////////////////////////////////////////
	a_ready_always: assert property (access |-> pready)
		else $error("access without ready");
	a_unmapped_err: assert property (access ##0 paddr == 12'h024 |-> pslverr)
		else $error("unmapped access accepted");
	a_mapped_ok: assert property (access ##0 paddr == 12'h004 |-> !pslverr)
		else $error("mapped access refused");
	a_err_reads_zero: assert property (access ##0 (!pwrite && pslverr) |-> prdata == 32'h0)
		else $error("refused read not zero");
	a_reset_quiet: assert property ($rose(arst_n) |-> quietPins [*2])
		else $error("pins busy after reset");
	a_irq0_pulse: assert property (periodIrq_r[0] |=> !periodIrq_r[0])
		else $error("irq0 longer than a cycle");
	a_irq1_pulse: assert property (periodIrq_r[1] |=> !periodIrq_r[1])
		else $error("irq1 longer than a cycle");
	a_trig0_pulse: assert property (sampleTrigger_r[0] |=> !sampleTrigger_r[0])
		else $error("trigger0 longer than a cycle");
	a_trig1_pulse: assert property (sampleTrigger_r[1] |=> !sampleTrigger_r[1])
		else $error("trigger1 longer than a cycle");
endmodule
bind compare_timer_pwm compare_timer_pwm_props props_u (.sys_clk, .arst_n, .psel, .penable,
	.pwrite, .paddr, .pready, .prdata, .pslverr, .axis4Phase, .axis5Phase, .axis6Phase,
	.sampleTrigger_r, .periodIrq_r);

// [dv/compare_timer_pwm_bench.sv]
`include "compare_timer_pwm_defines.vh"
module compare_timer_pwm_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic pwmTimerSyncOut = 0, tripIn = 0, e;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, q;
	wire pready, pslverr, fault;
	wire [31:0] prdata;
	wire [5:0] axis4Phase, axis5Phase, axis6Phase;
	wire [1:0] sampleTrigger_r, periodIrq_r;
	int num_errors = 0, total_checks = 0, n;
	compare_timer_pwm dut_u (.sys_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pready, .prdata, .pslverr, .pwmTimerSyncOut, .tripIn, .axis4Phase, .axis5Phase,
		.axis6Phase, .sampleTrigger_r, .periodIrq_r);
	gate_driver_model model_u (.gates({axis4Phase, axis5Phase, axis6Phase}),
		.shootThrough(fault));
	always #2.5 sys_clk = ~sys_clk;
	////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Slave answers at once, but the master still waits for ready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic err);
		apb(1'b0, a, 32'h0);
		chk(q, x);
		chk({31'h0, e}, {31'h0, err});
	endtask
	// Edges from one period pulse to the next
	task automatic gap(input int b);
		n = 0;
		do @(posedge sys_clk); while (periodIrq_r[b] !== 1'b1);
		do begin
			@(posedge sys_clk);
			n++;
		end while (periodIrq_r[b] !== 1'b1);
	endtask
	// Four edges after the trigger: one short of a three-cycle dead-band
	// Second trigger sits one count after the first
	task automatic pins(input logic [5:0] x4, input logic [5:0] x5, input logic [5:0] x6);
		do @(posedge sys_clk); while (sampleTrigger_r[0] !== 1'b1);
		@(posedge sys_clk);
		chk({31'h0, sampleTrigger_r[1]}, 32'h1);
		repeat (3) @(posedge sys_clk);
		chk({14'h0, axis4Phase, axis5Phase, axis6Phase}, {14'h0, x4, x5, x6});
	endtask
	task automatic close_out;
		$display("Checks %0d, errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		repeat (2) @(posedge sys_clk);
		arst_n <= 1'b1;
		rd(`REG_PERIOD0, `PERIOD_RESET, 1'b0);
		rd(`REG_PERIOD1, `PERIOD_RESET, 1'b0);
		rd(`REG_ACT_LVL, 32'h3FFFF, 1'b0);
		rd(12'h024, 32'h0, 1'b1);
		rd(12'h006, 32'h0, 1'b1);
		$display("Reset and map test done");
		wr(`REG_PERIOD0, 32'h13);
		wr(`REG_PERIOD1, 32'h13);
		wr(`REG_OUT_EN, 32'h3FFFF);
		// Unused channels sit past the period so they never match
		for (n = 0; n < 20; n++) begin
			wr(12'(`REG_CMP_BASE + 4 * n), (n % 6 == 0) ? 32'h5 : (n == 19) ? 32'h6 : 32'h100);
		end
		wr(`REG_CTRL, 32'h1);
		gap(0);
		chk(n, 32'd20);
		gap(1);
		chk(n, 32'd20);
		wr(12'(`REG_CMP_BASE + 4 * 6), 32'h5);
		pins(6'h01, 6'h01, 6'h01);
		chk({31'h0, fault}, 32'h0);
		$display("Period and phase test done");
		wr(`REG_OUT_EN, 32'h3FFFE);
		pins(6'h01, 6'h01, 6'h00);
		wr(`REG_DEADBAND, 32'h3);
		pins(6'h00, 6'h00, 6'h00);
		$display("Enable and dead-band test done");
		wr(`REG_TRIP_LVL, 32'h3FFFF);
		tripIn <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk({14'h0, axis4Phase, axis5Phase, axis6Phase}, 32'h3FFFE);
		tripIn <= 1'b0;
		wr(`REG_INIT_LVL, 32'h1);
		wr(`REG_CTRL, 32'h3);
		repeat (2) @(posedge sys_clk);
		chk({14'h0, axis4Phase, axis5Phase, axis6Phase}, 32'h3FFFF);
		pwmTimerSyncOut <= 1'b1;
		rd(`REG_STATUS, 32'h0, 1'b0);
		pwmTimerSyncOut <= 1'b0;
		$display("Trip and sync test done");
		close_out;
	end
	// Tests need a few hundred cycles; this allows some thousands
	initial begin
		#20000;
		num_errors++;
		close_out;
	end
endmodule
